// file: hw/fsr_map.svh
`ifndef FSR_MAP_SVH
`define FSR_MAP_SVH

// ****************************************************************
// Register offsets on the host bus
// ****************************************************************
`define FSR_ASYNC_STATUS_ADDR 8'h30
`define FSR_ISO_STATUS_ADDR 8'h34
`define FSR_RX_STATUS_ADDR 8'h3C
`define FSR_TEST_DATA_ADDR 8'h80
`define FSR_ISO_DATA_ADDR 8'h84
`define FSR_REG_RESET 32'h0000_0000

// ****************************************************************
// Field positions
// ****************************************************************
`define FSR_BIT_FULL 0
`define FSR_BIT_EMPTY 1
`define FSR_BIT_MISMATCH 2
`define FSR_BIT_PTR_CLEAR 3
`define FSR_BIT_CTRL 4
`define FSR_BIT_TEST 5
`define FSR_PTR_LSB 6
`define FSR_PTR_MSB 14
`define FSR_FREE_LSB 23
`define FSR_FREE_MSB 31
`define FSR_RX_BIT_EMPTY 0
`define FSR_RX_BIT_TOKEN 1
`define FSR_RX_BIT_LAST 2
`define FSR_RX_TOTAL_LSB 3
`define FSR_RX_TOTAL_MSB 12
`define FSR_RX_SIZE_LSB 13
`define FSR_RX_SIZE_MSB 22
`define FSR_RX_NEXT_LSB 23
`define FSR_RX_NEXT_MSB 31

// ****************************************************************
// Memory geometry
// ****************************************************************
`define FSR_MEM_WORDS 10'h200
`define FSR_MARKER_BIT 32

`endif

// file: hw/fsr_pkg.sv
package fsr_pkg;

  typedef struct packed {
    logic [8:0] test_pointer;
    logic test_pointer_clear;
    logic ctrl;
    logic memory_test_enable;
    logic marker_bit_mismatch;
    logic [31:0] rdata;
    logic rvalid;
  } fsr_state_t;

endpackage : fsr_pkg

// file: hw/fsr_qcount.sv
// ****************************************************************
// Fill level of one queue, tracked from push and pop events
// ****************************************************************
module fsr_qcount #(
  parameter int W = 10
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic en_i,
  input wire logic inc_i,
  input wire logic dec_i,
  output logic [W-1:0] level_o
);

  logic [W-1:0] level;
  logic [W-1:0] next_level;

  always_comb begin
    next_level = level;
    // Frozen while the memory is under test
    if (en_i && inc_i && !dec_i) begin
      next_level = level + W'(1);
    end else if (en_i && dec_i && !inc_i && level != '0) begin
      next_level = level - W'(1);
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      level <= '0;
    end else begin
      level <= next_level;
    end
  end

  assign level_o = level;

endmodule // fsr_qcount

// file: hw/fsr_skid.sv
// ****************************************************************
// Two-entry buffer with valid and ready on both sides
// ****************************************************************
module fsr_skid #(
  parameter int WIDTH = 32
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);

  typedef struct packed {
    logic [WIDTH-1:0] head;
    logic [WIDTH-1:0] tail;
    logic [1:0] count;
    logic out_valid;
  } fsr_skid_state_t;

  fsr_skid_state_t st;
  fsr_skid_state_t next_st;
  logic push;
  logic pop;

  assign in_ready_o = (st.count != 2'h2);
  // Kept as its own flop so the stream valid leaves no gate behind it
  assign out_valid_o = st.out_valid;
  assign out_data_o = st.head;
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;

  always_comb begin
    next_st = st;
    if (pop) begin
      next_st.head = st.tail;
    end
    if (push) begin
      // Lands in head when buffer empties, otherwise behind it
      if (st.count == 2'h0 || (st.count == 2'h1 && pop)) begin
        next_st.head = in_data_i;
      end else begin
        next_st.tail = in_data_i;
      end
    end
    next_st.count = st.count + {1'b0, push} - {1'b0, pop};
    next_st.out_valid = (next_st.count != 2'h0);
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

endmodule // fsr_skid

// file: hw/fsr_top.sv
// Operation
// R1 - Test write stores control bit plus data
// R2 - Test read flags marker bit mismatch
// R3 - Test mode disables all queue functions; code still lets the iso buffer drain held words to the stream
// R4 - Test data address reaches pointed location
// R5 - Pointer advances after each test access
// R6 - Pointer sits in bits 6-14, 0-511
// R7 - Clear test enable for normal operation
// R8 - Async status reports free quadlets
// R9 - Software bursts only when space suffices
// R10 - Iso queue full ignores host writes
// R11 - Iso empty flag when queue empty
// R12 - Iso status reports free quadlets
// R13 - Flags read-only, control bits read-write
// R14 - Receive empty flag when queue empty
// R15 - Token flag when token at head
// R16 - Last-block bit marks packet end
// R17 - No split or flush: whole packet
// R18 - Last-block bit meaningless without token
// R19 - Receive total stored quadlets reported
// R20 - Assigned space is 512 minus transmit
// R21 - Next block quadlets, valid with token
// R22 - Software reads block plus token quadlet
// R23 - Memory words are 33 bits wide
// R24 - Pointer clear acts at next access
// R25 - Mismatch cleared by clear or disable
// R26 - Counts track every push and pop; code drops pushes and pops made in test mode
`include "fsr_map.svh"

module fsr_top #(
  parameter int DEPTH = 512,
  parameter int AW = 9
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [7:0] host_addr_i,
  input wire logic host_wr_i,
  input wire logic host_rd_i,
  input wire logic [31:0] host_wdata_i,
  output logic [31:0] host_rdata_o,
  output logic host_rvalid_o,
  input wire logic [9:0] async_size_i,
  input wire logic [9:0] iso_size_i,
  input wire logic async_push_i,
  input wire logic async_pop_i,
  input wire logic iso_pop_i,
  input wire logic rx_push_i,
  input wire logic rx_pop_i,
  input wire logic rx_token_at_head_i,
  input wire logic rx_head_last_i,
  input wire logic [8:0] rx_head_block_quadlets_i,
  input wire logic split_enable_i,
  input wire logic flush_bad_packets_i,
  output logic [31:0] iso_data_o,
  output logic iso_valid_o,
  input wire logic iso_ready_i,
  output logic memory_test_enable_o
);

  // ****************************************************************
  // State
  // ****************************************************************
  fsr_pkg::fsr_state_t st;
  fsr_pkg::fsr_state_t next_st;
  logic [32:0] mem [DEPTH];
  logic [9:0] async_level;
  logic [9:0] iso_level;
  logic [9:0] rx_level;
  logic iso_in_ready;
  logic iso_accept;
  logic test_wr;
  logic test_rd;
  logic [AW-1:0] access_addr;
  logic [32:0] mem_word;
  logic [9:0] async_free;
  logic [9:0] iso_free;
  logic [9:0] rx_space;
  logic async_full;
  logic iso_full;
  logic rx_last;
  logic [31:0] rd_word;

  // R4 - test data port
  assign test_wr = host_wr_i && host_addr_i == `FSR_TEST_DATA_ADDR && st.memory_test_enable;
  assign test_rd = host_rd_i && host_addr_i == `FSR_TEST_DATA_ADDR && st.memory_test_enable;
  // R24 - pending clear addresses location zero
  assign access_addr = st.test_pointer_clear ? '0 : st.test_pointer;
  assign mem_word = mem[access_addr];

  // ****************************************************************
  // Queue levels
  // ****************************************************************
  // R10 - full refuses writes, R3 - test mode blocks them
  assign iso_accept = host_wr_i && host_addr_i == `FSR_ISO_DATA_ADDR && !iso_full
                      && iso_in_ready && !st.memory_test_enable;

  // R26 - counts follow every push and pop made outside test mode
  fsr_qcount #(.W(10)) u_async_level (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .en_i(!st.memory_test_enable),
    .inc_i(async_push_i),
    .dec_i(async_pop_i),
    .level_o(async_level)
  );

  fsr_qcount #(.W(10)) u_iso_level (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .en_i(!st.memory_test_enable),
    .inc_i(iso_accept),
    .dec_i(iso_pop_i),
    .level_o(iso_level)
  );

  fsr_qcount #(.W(10)) u_rx_level (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .en_i(!st.memory_test_enable),
    .inc_i(rx_push_i),
    .dec_i(rx_pop_i),
    .level_o(rx_level)
  );

  // A stall by the iso queue is held here, and refused by in_ready
  fsr_skid #(.WIDTH(32)) u_iso_buf (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .in_valid_i(iso_accept),
    .in_ready_o(iso_in_ready),
    .in_data_i(host_wdata_i),
    .out_valid_o(iso_valid_o),
    .out_ready_i(iso_ready_i),
    .out_data_o(iso_data_o)
  );

  // R8 - async free space
  assign async_free = async_size_i - async_level;
  // R12 - iso free space
  assign iso_free = iso_size_i - iso_level;
  assign async_full = (async_level >= async_size_i);
  assign iso_full = (iso_level >= iso_size_i);
  // R20 - receive share of the memory
  assign rx_space = `FSR_MEM_WORDS - async_size_i - iso_size_i;
  // R17 - unsplit packets are always one complete block
  assign rx_last = (!split_enable_i || flush_bad_packets_i) ? 1'b1 : rx_head_last_i;

  // ****************************************************************
  // Read multiplexer
  // ****************************************************************
  always_comb begin
    rd_word = `FSR_REG_RESET;
    case (host_addr_i)
      `FSR_ASYNC_STATUS_ADDR: begin
        rd_word[`FSR_BIT_FULL] = async_full;
        rd_word[`FSR_BIT_EMPTY] = (async_level == '0);
        // R13 - flags read-only, controls read back
        rd_word[`FSR_BIT_MISMATCH] = st.marker_bit_mismatch;
        rd_word[`FSR_BIT_PTR_CLEAR] = st.test_pointer_clear;
        rd_word[`FSR_BIT_CTRL] = st.ctrl;
        rd_word[`FSR_BIT_TEST] = st.memory_test_enable;
        // R6 - pointer field
        rd_word[`FSR_PTR_MSB:`FSR_PTR_LSB] = st.test_pointer;
        rd_word[`FSR_FREE_MSB:`FSR_FREE_LSB] = async_free[8:0];
      end
      `FSR_ISO_STATUS_ADDR: begin
        rd_word[`FSR_BIT_FULL] = iso_full;
        // R11 - iso empty
        rd_word[`FSR_BIT_EMPTY] = (iso_level == '0);
        rd_word[`FSR_FREE_MSB:`FSR_FREE_LSB] = iso_free[8:0];
      end
      `FSR_RX_STATUS_ADDR: begin
        // R14 - receive empty
        rd_word[`FSR_RX_BIT_EMPTY] = (rx_level == '0);
        // R15 - token at head
        rd_word[`FSR_RX_BIT_TOKEN] = rx_token_at_head_i;
        // R16 - last block, R18 - left as-is without token
        rd_word[`FSR_RX_BIT_LAST] = rx_last;
        // R19 - total stored
        rd_word[`FSR_RX_TOTAL_MSB:`FSR_RX_TOTAL_LSB] = rx_level;
        rd_word[`FSR_RX_SIZE_MSB:`FSR_RX_SIZE_LSB] = rx_space;
        // R21 - next block size, token not counted
        rd_word[`FSR_RX_NEXT_MSB:`FSR_RX_NEXT_LSB] = rx_head_block_quadlets_i;
      end
      `FSR_TEST_DATA_ADDR: begin
        if (st.memory_test_enable) begin
          rd_word = mem_word[31:0];
        end
      end
      default: begin
        rd_word = `FSR_REG_RESET;
      end
    endcase
  end

  // ****************************************************************
  // Control and test state
  // ****************************************************************
  always_comb begin
    next_st = st;
    next_st.rvalid = host_rd_i;
    next_st.rdata = host_rd_i ? rd_word : st.rdata;
    if (host_wr_i && host_addr_i == `FSR_ASYNC_STATUS_ADDR) begin
      next_st.ctrl = host_wdata_i[`FSR_BIT_CTRL];
      // R7 - test enable written by software
      next_st.memory_test_enable = host_wdata_i[`FSR_BIT_TEST];
      if (host_wdata_i[`FSR_BIT_PTR_CLEAR]) begin
        next_st.test_pointer_clear = 1'b1;
      end
      // R25 - clear or leaving test mode drops the mismatch
      if (host_wdata_i[`FSR_BIT_PTR_CLEAR] || !host_wdata_i[`FSR_BIT_TEST]) begin
        next_st.marker_bit_mismatch = 1'b0;
      end
    end
    if (test_wr || test_rd) begin
      // R5 - advance after every access, R24 - clear self-resets
      next_st.test_pointer = access_addr + AW'(1);
      next_st.test_pointer_clear = 1'b0;
    end
    // R2 - marker compare on test read
    if (test_rd && mem_word[`FSR_MARKER_BIT] != st.ctrl) begin
      next_st.marker_bit_mismatch = 1'b1;
    end else if (test_rd && st.test_pointer_clear) begin
      next_st.marker_bit_mismatch = 1'b0;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // R1 - marker bit joined with data, R23 - 33-bit words
  always_ff @(posedge clk_i) begin
    if (test_wr) begin
      mem[access_addr] <= {st.ctrl, host_wdata_i};
    end
  end

  assign host_rdata_o = st.rdata;
  assign host_rvalid_o = st.rvalid;
  // R3 - datapaths see the test mode and stand still
  assign memory_test_enable_o = st.memory_test_enable;

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  ptr_advance_a: assert property ((test_wr || test_rd) |=> // R5
    st.test_pointer == $past(access_addr) + AW'(1))
    else $error("test pointer did not advance");

  ptr_clear_a: assert property ((test_rd || test_wr) && st.test_pointer_clear |=> // R24
    st.test_pointer == AW'(1) && !st.test_pointer_clear)
    else $error("pointer clear not applied");

  mismatch_set_a: assert property (test_rd && mem_word[`FSR_MARKER_BIT] != st.ctrl |=> // R2
    st.marker_bit_mismatch)
    else $error("marker mismatch not flagged");

  mismatch_clr_a: assert property (host_wr_i && host_addr_i == `FSR_ASYNC_STATUS_ADDR // R25
    && !host_wdata_i[`FSR_BIT_TEST] |=> !st.marker_bit_mismatch)
    else $error("mismatch not cleared");

  iso_full_a: assert property (iso_full && !iso_pop_i |=> $stable(iso_level)) // R10
    else $error("iso level rose while queue full");

  test_freeze_a: assert property (st.memory_test_enable && !host_wr_i |=> // R3
    $stable(iso_level) && $stable(rx_level) && $stable(async_level))
    else $error("queue level moved in test mode");

  read_answer_a: assert property (host_rd_i && host_addr_i == `FSR_ISO_STATUS_ADDR |=> // R11
    host_rvalid_o && host_rdata_o[`FSR_BIT_EMPTY] == ($past(iso_level) == '0))
    else $error("iso empty flag wrong");

  whole_packet_a: assert property (host_rd_i && host_addr_i == `FSR_RX_STATUS_ADDR // R17
    && (!split_enable_i || flush_bad_packets_i) ##1 1'b1 |-> host_rdata_o[`FSR_RX_BIT_LAST])
    else $error("unsplit packet not complete");

  test_write_a: assert property (test_wr |=> // R1
    mem[$past(access_addr)] == {$past(st.ctrl), $past(host_wdata_i)})
    else $error("test write stored wrong word");

  rx_empty_a: assert property (host_rd_i && host_addr_i == `FSR_RX_STATUS_ADDR |=> // R14
    host_rdata_o[`FSR_RX_BIT_EMPTY] == ($past(rx_level) == '0))
    else $error("receive empty flag wrong");

  token_flag_a: assert property (host_rd_i && host_addr_i == `FSR_RX_STATUS_ADDR |=> // R15
    host_rdata_o[`FSR_RX_BIT_TOKEN] == $past(rx_token_at_head_i))
    else $error("token flag wrong");

  ptr_field_a: assert property (host_rd_i && host_addr_i == `FSR_ASYNC_STATUS_ADDR |=> // R6
    host_rdata_o[`FSR_PTR_MSB:`FSR_PTR_LSB] == $past(st.test_pointer))
    else $error("pointer field wrong");

  clear_drop_a: assert property (host_wr_i && host_addr_i == `FSR_ASYNC_STATUS_ADDR // R25
    && host_wdata_i[`FSR_BIT_PTR_CLEAR] |=> !st.marker_bit_mismatch)
    else $error("mismatch kept after pointer clear");

endmodule // fsr_top

// file: testbench/fsr_sink.sv
// ****************************************************************
// Iso stream sink, stalls on command
// ****************************************************************
module fsr_sink (
  input wire logic clk_i,
  input wire logic stall_i,
  input wire logic valid_i,
  input wire logic [31:0] data_i,
  output logic ready_o
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [31:0] got [0:7];
  int cnt = 0;
  initial ready_o = 1'b0;
  // Ready moves by NBA on the sampling edge, so a stall never races a transfer
  always @(posedge clk_i) begin
    ready_o <= !stall_i;
  end
  always @(posedge clk_i) begin
    if (valid_i && ready_o) begin
      got[cnt[2:0]] <= data_i;
      cnt <= cnt + 1;
    end
  end
endmodule // fsr_sink

// file: testbench/tb.sv
`include "fsr_map.svh"
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin err_count++; \
  $display("MISMATCH t=%0t got=%0h exp=%0h", $time, (a), (e)); end end

module tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] addr = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [31:0] wdata = 32'h0000_0000;
  logic [31:0] rdata;
  logic rvalid;
  logic [9:0] asz = 10'h064;
  logic [9:0] isz = 10'h004;
  logic apush = 1'b0;
  logic apop = 1'b0;
  logic ipop = 1'b0;
  logic rpush = 1'b0;
  logic rpop = 1'b0;
  logic tok = 1'b0;
  logic last = 1'b0;
  logic [8:0] nblk = 9'h000;
  logic split = 1'b0;
  logic flush = 1'b0;
  logic [31:0] idata;
  logic ivalid;
  logic iready;
  logic mte;
  logic stall = 1'b0;
  logic [31:0] r;
  int err_count = 0;
  int check_count = 0;

  always #12.5 clk = ~clk;

  fsr_top #(.DEPTH(512), .AW(9)) fsr_top_i (.clk_i(clk), .rst_n_i(rst_n),
    .host_addr_i(addr), .host_wr_i(wr), .host_rd_i(rd), .host_wdata_i(wdata),
    .host_rdata_o(rdata), .host_rvalid_o(rvalid), .async_size_i(asz), .iso_size_i(isz),
    .async_push_i(apush), .async_pop_i(apop), .iso_pop_i(ipop), .rx_push_i(rpush),
    .rx_pop_i(rpop), .rx_token_at_head_i(tok), .rx_head_last_i(last),
    .rx_head_block_quadlets_i(nblk), .split_enable_i(split),
    .flush_bad_packets_i(flush), .iso_data_o(idata), .iso_valid_o(ivalid),
    .iso_ready_i(iready), .memory_test_enable_o(mte));

  fsr_sink fsr_sink_i (.clk_i(clk), .stall_i(stall), .valid_i(ivalid), .data_i(idata),
    .ready_o(iready));

  // ****************************************************************
  // Bus and event helpers
  // ****************************************************************
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(negedge clk);
    addr = a;
    wdata = d;
    wr = 1'b1;
    @(negedge clk);
    wr = 1'b0;
  endtask

  task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
    @(negedge clk);
    addr = a;
    rd = 1'b1;
    @(negedge clk);
    rd = 1'b0;
    `CHK(rvalid, 1'b1);
    d = rdata;
  endtask

  task automatic pulse(input int k, input int n);
    repeat (n) begin
      @(negedge clk);
      case (k)
        0: apush = 1'b1;
        1: apop = 1'b1;
        2: ipop = 1'b1;
        3: rpush = 1'b1;
        default: rpop = 1'b1;
      endcase
      @(negedge clk);
      {apush, apop, ipop, rpush, rpop} = 5'h00;
    end
  endtask

  task automatic end_of_test();
    $display("checks=%0d mismatches=%0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_async();
    rd_reg(`FSR_ASYNC_STATUS_ADDR, r);
    `CHK(r[5:3], 3'h0);
    `CHK(mte, 1'b0);
    pulse(0, 3);
    rd_reg(`FSR_ASYNC_STATUS_ADDR, r);
    `CHK(r[1:0], 2'h0);
    `CHK(r[31:23], 9'h061);
    pulse(1, 3);
    rd_reg(`FSR_ASYNC_STATUS_ADDR, r);
    `CHK(r[31:23], 9'h064);
    $display("test async done");
  endtask

  task automatic t_iso();
    rd_reg(`FSR_ISO_STATUS_ADDR, r);
    `CHK(r[1:0], 2'h2);
    `CHK(r[31:23], 9'h004);
    `CHK(r[31:23] > 9'h003, 1'b1);
    stall = 1'b1;
    for (int i = 0; i < 3; i++) begin
      wr_reg(`FSR_ISO_DATA_ADDR, 32'hA000_0000 + i);
    end
    repeat (4) @(negedge clk);
    `CHK(fsr_sink_i.cnt, 0);
    stall = 1'b0;
    repeat (4) @(negedge clk);
    `CHK(fsr_sink_i.cnt, 2);
    `CHK(fsr_sink_i.got[1], 32'hA000_0001);
    rd_reg(`FSR_ISO_STATUS_ADDR, r);
    `CHK(r[31:23], 9'h002);
    for (int i = 0; i < 3; i++) begin
      wr_reg(`FSR_ISO_DATA_ADDR, 32'hB000_0000 + i);
    end
    repeat (4) @(negedge clk);
    `CHK(fsr_sink_i.cnt, 4);
    `CHK(fsr_sink_i.got[3], 32'hB000_0001);
    rd_reg(`FSR_ISO_STATUS_ADDR, r);
    `CHK(r, 32'h0000_0001);
    pulse(2, 4);
    rd_reg(`FSR_ISO_STATUS_ADDR, r);
    `CHK(r, 32'h0200_0002);
    $display("test iso done");
  endtask

  task automatic t_rx();
    tok = 1'b1;
    nblk = 9'h004;
    split = 1'b1;
    pulse(3, 5);
    rd_reg(`FSR_RX_STATUS_ADDR, r);
    `CHK(r, {9'h004, 10'h198, 10'h005, 3'h2});
    `CHK(r[22:13], 10'h198);
    `CHK(r[12:3], 10'h005);
    `CHK(r[2:1], 2'h1);
    split = 1'b0;
    rd_reg(`FSR_RX_STATUS_ADDR, r);
    `CHK(r[2:1], 2'h3);
    split = 1'b1;
    flush = 1'b1;
    rd_reg(`FSR_RX_STATUS_ADDR, r);
    `CHK(r[2:1], 2'h3);
    flush = 1'b0;
    last = 1'b1;
    rd_reg(`FSR_RX_STATUS_ADDR, r);
    `CHK(r[2:1], 2'h3);
    `CHK(r[1], 1'b1);
    // Software pops the token and the block behind it
    tok = 1'b0;
    pulse(4, int'(nblk) + 1);
    rd_reg(`FSR_RX_STATUS_ADDR, r);
    `CHK(r[0], 1'b1);
    `CHK(r[1], 1'b0);
    `CHK(r[12:3], 10'h000);
    $display("test rx done");
  endtask

  task automatic t_mem();
    wr_reg(`FSR_ASYNC_STATUS_ADDR, 32'h0000_0038);
    `CHK(mte, 1'b1);
    for (int i = 0; i < 3; i++) begin
      wr_reg(`FSR_TEST_DATA_ADDR, 32'hC0DE_0000 + i);
    end
    rd_reg(`FSR_ASYNC_STATUS_ADDR, r);
    `CHK(r[14:3], 12'h01E);
    wr_reg(`FSR_ASYNC_STATUS_ADDR, 32'h0000_0038);
    for (int i = 0; i < 3; i++) begin
      rd_reg(`FSR_TEST_DATA_ADDR, r);
      `CHK(r, 32'hC0DE_0000 + i);
    end
    rd_reg(`FSR_ASYNC_STATUS_ADDR, r);
    `CHK(r[2], 1'b0);
    `CHK(r[14:6], 9'h003);
    wr_reg(`FSR_ASYNC_STATUS_ADDR, 32'h0000_0028);
    rd_reg(`FSR_TEST_DATA_ADDR, r);
    `CHK(r, 32'hC0DE_0000);
    rd_reg(`FSR_ASYNC_STATUS_ADDR, r);
    `CHK(r[2], 1'b1);
    `CHK(r[14:6], 9'h001);
    wr_reg(`FSR_ISO_DATA_ADDR, 32'hD000_0000);
    repeat (3) @(negedge clk);
    `CHK(fsr_sink_i.cnt, 4);
    pulse(3, 2);
    wr_reg(`FSR_ASYNC_STATUS_ADDR, 32'h0000_0028);
    repeat (513) wr_reg(`FSR_TEST_DATA_ADDR, 32'h0000_0000);
    rd_reg(`FSR_ASYNC_STATUS_ADDR, r);
    `CHK(r[14:6], 9'h001);
    `CHK(r[2], 1'b0);
    // Marker stored as 0 is read back against control 1
    wr_reg(`FSR_ASYNC_STATUS_ADDR, 32'h0000_0038);
    rd_reg(`FSR_TEST_DATA_ADDR, r);
    rd_reg(`FSR_ASYNC_STATUS_ADDR, r);
    `CHK(r[2], 1'b1);
    wr_reg(`FSR_ASYNC_STATUS_ADDR, 32'h0000_0000);
    rd_reg(`FSR_ASYNC_STATUS_ADDR, r);
    `CHK(r[5:2], 4'h0);
    `CHK(mte, 1'b0);
    rd_reg(`FSR_TEST_DATA_ADDR, r);
    `CHK(r, 32'h0000_0000);
    rd_reg(`FSR_RX_STATUS_ADDR, r);
    `CHK(r[12:3], 10'h000);
    $display("test mem done");
  endtask

  task automatic t_misc();
    rd_reg(8'h40, r);
    `CHK(r, 32'h0000_0000);
    wr_reg(`FSR_ISO_STATUS_ADDR, 32'hFFFF_FFFF);
    rd_reg(`FSR_ISO_STATUS_ADDR, r);
    `CHK(r, 32'h0200_0002);
    $display("test misc done");
  endtask

  // ****************************************************************
  // Main sequence and watchdog
  // ****************************************************************
  initial begin
    repeat (10) @(negedge clk);
    rst_n = 1'b1;
    t_async();
    t_iso();
    t_rx();
    t_mem();
    t_misc();
    end_of_test();
  end

  // Whole run is near 1200 cycles; allow over sixteen times that
  initial begin
    #(25 * 20000);
    err_count++;
    end_of_test();
  end
endmodule // tb
